/* File: src/djc_pkg.sv */
// constants, addresses and types for the drive i/o function and jog block
package djc_pkg;
  // parameter addresses
  localparam logic [15:0] ADDR_REF_POL    = 16'h061c;
  localparam logic [15:0] ADDR_NEG_POL    = 16'h061e;
  localparam logic [15:0] ADDR_POS_POL    = 16'h0620;
  localparam logic [15:0] ADDR_HALT       = 16'h062e;
  localparam logic [15:0] ADDR_PIN2_FN    = 16'h0724;
  localparam logic [15:0] ADDR_PIN3_FN    = 16'h0726;
  localparam logic [15:0] ADDR_PIN4_FN    = 16'h0728;
  localparam logic [15:0] ADDR_DIRECT_OUT = 16'h0822;
  localparam logic [15:0] ADDR_SLOW       = 16'h2908;
  localparam logic [15:0] ADDR_FAST       = 16'h290a;
  localparam logic [15:0] ADDR_STEP       = 16'h290e;
  localparam logic [15:0] ADDR_WAIT       = 16'h2910;
  localparam logic [15:0] ADDR_JOG_CTRL   = 16'h2912;
  localparam logic [15:0] ADDR_STATUS     = 16'h2914;
  // reset values
  localparam logic [15:0] RST_POL         = 16'h0001;
  localparam logic [15:0] RST_HALT        = 16'h0003;
  localparam logic [15:0] RST_FN          = 16'h0000;
  localparam logic [15:0] RST_SLOW        = 16'h003c;
  localparam logic [15:0] RST_FAST        = 16'h00b4;
  localparam logic [31:0] RST_STEP        = 32'h00000014;
  localparam logic [15:0] RST_WAIT        = 16'h01f4;
  localparam logic [15:0] RST_ZERO        = 16'h0000;
  // pin function codes
  localparam logic [15:0] FN_IN_FREE      = 16'h0001;
  localparam logic [15:0] FN_FAULT_RESET  = 16'h0002;
  localparam logic [15:0] FN_ENABLE       = 16'h0003;
  localparam logic [15:0] FN_HALT         = 16'h0004;
  localparam logic [15:0] FN_JOG_POS      = 16'h0009;
  localparam logic [15:0] FN_JOG_NEG      = 16'h000a;
  localparam logic [15:0] FN_JOG_FAST     = 16'h000b;
  localparam logic [15:0] FN_REF_SWITCH   = 16'h0014;
  localparam logic [15:0] FN_NEG_LIMIT    = 16'h0016;
  localparam logic [15:0] FN_OUT_FREE     = 16'h0065;
  localparam logic [15:0] FN_OUT_NO_FAULT = 16'h0066;
  localparam logic [15:0] FN_OUT_READY    = 16'h0067;
  // switch evaluation and halt codes
  localparam logic [15:0] POL_OFF         = 16'h0000;
  localparam logic [15:0] POL_NC          = 16'h0001;
  localparam logic [15:0] POL_NO          = 16'h0002;
  localparam logic [15:0] HALT_DECEL      = 16'h0001;
  localparam logic [15:0] HALT_TORQUE     = 16'h0003;
  // value limits
  localparam logic [31:0] SPEED_MIN       = 32'h00000001;
  localparam logic [31:0] SPEED_MAX       = 32'h00003390;
  localparam logic [31:0] WAIT_MIN        = 32'h00000001;
  localparam logic [31:0] WAIT_MAX        = 32'h00007fff;
  localparam logic [31:0] JOG_CTRL_MAX    = 32'h00000007;
  localparam logic [31:0] HALF_MAX        = 32'h0000ffff;
  // jog request bit positions
  localparam int JOG_BIT_POS  = 0;
  localparam int JOG_BIT_NEG  = 1;
  localparam int JOG_BIT_FAST = 2;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {JOG_IDLE, JOG_STEP_WAIT, JOG_CONT} djc_jog_state_t;
endpackage

/* File: src/djc_in_filter.sv */
// three-stage input synchroniser with agreement filter
module djc_in_filter #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  // raw pins and filtered levels
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_d;

  // a bit moves only when stages two and three agree, else it holds; s1 feeds s2 alone
  assign level_d = (s2_q & ~(s2_q ^ s3_q)) | (level_out & (s2_q ^ s3_q));

  // chain of three flops, then the filtered level
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s1_q      <= '0;
      s2_q      <= '0;
      s3_q      <= '0;
      level_out <= '0;
    end else begin
      s1_q      <= raw_in;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      level_out <= level_d;
    end
  end
endmodule

/* File: src/djc_core.sv */
// local pin functions, switch evaluation, jog control and halt selection
module djc_core
  import djc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // parameter access
  input  wire logic [15:0] par_addr_in,
  input  wire logic        par_wr_in,
  input  wire logic        par_rd_in,
  input  wire logic [31:0] par_wdata_in,
  output logic      [31:0] par_rdata_out,
  output logic             par_ack_out,
  output logic             par_err_out,
  // local pins two to four and the positive limit switch
  input  wire logic [2:0]  pin_in,
  output logic      [2:0]  pin_out,
  output logic      [2:0]  pin_oe_out,
  input  wire logic        positive_limit_switch_in,
  // drive state
  input  wire logic        local_mode_in,
  input  wire logic        homing_active_in,
  input  wire logic        profile_mode_in,
  input  wire logic        drive_fault_in,
  input  wire logic        drive_ready_in,
  input  wire logic [15:0] max_ramp_speed_in,
  // requests to the drive
  output logic             fault_reset_out,
  output logic             enable_out,
  output logic             halt_req_out,
  output logic             halt_decel_ramp_out,
  output logic             halt_torque_ramp_out,
  output logic             pos_limit_hit_out,
  output logic             neg_limit_hit_out,
  output logic             ref_hit_out,
  // jog motion requests
  output logic             jog_run_out,
  output logic             jog_neg_dir_out,
  output logic             jog_step_start_out,
  output logic      [31:0] jog_step_dist_out,
  output logic             jog_cont_out,
  output logic      [15:0] jog_speed_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  logic [15:0]    fn_q [0:2];
  logic [15:0]    ref_pol_q;
  logic [15:0]    neg_pol_q;
  logic [15:0]    pos_pol_q;
  logic [15:0]    halt_type_q;
  logic [15:0]    direct_q;
  logic [15:0]    slow_q;
  logic [15:0]    fast_q;
  logic [31:0]    step_q;
  logic [15:0]    wait_q;
  logic [15:0]    jog_ctrl_q;
  logic [3:0]     lvl;
  logic [2:0]     f_fr, f_en, f_halt, f_jp, f_jn, f_jf, f_ref_cfg, f_out;
  logic [2:0]     pin_d;
  djc_jog_state_t state_q, state_d;
  logic           dir_q;
  logic [16:0]    ms_cnt_q;
  logic [14:0]    ms_left_q;

  // synchronised pin levels: bit 3 is the positive limit switch
  djc_in_filter #(.WIDTH(4)) u_filter (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .raw_in     ({positive_limit_switch_in, pin_in}),
    .level_out  (lvl)
  );

  // legal function codes; zero leaves the pin unused
  function automatic logic fn_ok(input logic [31:0] c, input logic lim_ok);
    logic base;
    base = (c[31:16] == 16'h0000) && (c[15:0] inside {RST_FN, FN_IN_FREE,
      FN_FAULT_RESET, FN_ENABLE, FN_HALT, FN_JOG_POS, FN_JOG_NEG, FN_JOG_FAST,
      FN_REF_SWITCH, FN_OUT_FREE, FN_OUT_NO_FAULT, FN_OUT_READY});
    return base || (lim_ok && c == {16'h0000, FN_NEG_LIMIT});
  endfunction

  // address decode and value checks
  wire [31:0] wd        = par_wdata_in;
  wire hit_ref    = par_addr_in == ADDR_REF_POL;
  wire hit_neg    = par_addr_in == ADDR_NEG_POL;
  wire hit_pos    = par_addr_in == ADDR_POS_POL;
  wire hit_halt   = par_addr_in == ADDR_HALT;
  wire hit_fn2    = par_addr_in == ADDR_PIN2_FN;
  wire hit_fn3    = par_addr_in == ADDR_PIN3_FN;
  wire hit_fn4    = par_addr_in == ADDR_PIN4_FN;
  wire hit_dir    = par_addr_in == ADDR_DIRECT_OUT;
  wire hit_slow   = par_addr_in == ADDR_SLOW;
  wire hit_fast   = par_addr_in == ADDR_FAST;
  wire hit_step   = par_addr_in == ADDR_STEP;
  wire hit_wait   = par_addr_in == ADDR_WAIT;
  wire hit_jog    = par_addr_in == ADDR_JOG_CTRL;
  wire hit_stat   = par_addr_in == ADDR_STATUS;
  wire ok_lim     = wd <= {16'h0000, POL_NO};
  wire ok_ref     = wd == {16'h0000, POL_NC} || wd == {16'h0000, POL_NO};
  wire ok_halt    = wd == {16'h0000, HALT_DECEL} || wd == {16'h0000, HALT_TORQUE};
  wire ok_speed   = wd >= SPEED_MIN && wd <= SPEED_MAX;
  wire ok_wait    = wd >= WAIT_MIN && wd <= WAIT_MAX;
  wire ok_jog     = wd <= JOG_CTRL_MAX;
  wire ok_half    = wd <= HALF_MAX;
  wire ok_step    = !wd[31];
  wire wr_ok      = (hit_ref & ok_ref) | ((hit_neg | hit_pos) & ok_lim)
                  | (hit_halt & ok_halt) | (hit_fn2 & fn_ok(wd, 1'b1))
                  | ((hit_fn3 | hit_fn4) & fn_ok(wd, 1'b0)) | (hit_dir & ok_half)
                  | ((hit_slow | hit_fast) & ok_speed) | (hit_step & ok_step)
                  | (hit_wait & ok_wait) | (hit_jog & ok_jog);
  wire wr_go      = par_wr_in & wr_ok;
  wire rd_hit     = hit_ref | hit_neg | hit_pos | hit_halt | hit_fn2 | hit_fn3
                  | hit_fn4 | hit_dir | hit_slow | hit_fast | hit_step | hit_wait
                  | hit_jog | hit_stat;
  wire [31:0] stat_w = {21'h00000, lvl[2:0], 2'h0, jog_neg_dir_out, ref_hit_out,
                        neg_limit_hit_out, pos_limit_hit_out, 2'(state_q)};
  wire [31:0] rd_val =
      hit_ref  ? {16'h0000, ref_pol_q}   : hit_neg  ? {16'h0000, neg_pol_q}  :
      hit_pos  ? {16'h0000, pos_pol_q}   : hit_halt ? {16'h0000, halt_type_q} :
      hit_fn2  ? {16'h0000, fn_q[0]}     : hit_fn3  ? {16'h0000, fn_q[1]}    :
      hit_fn4  ? {16'h0000, fn_q[2]}     : hit_dir  ? {16'h0000, direct_q}   :
      hit_slow ? {16'h0000, slow_q}      : hit_fast ? {16'h0000, fast_q}     :
      hit_step ? step_q                  : hit_wait ? {16'h0000, wait_q}     :
      hit_jog  ? {16'h0000, jog_ctrl_q}  : hit_stat ? stat_w : 32'h00000000;

  // settings; a rejected write leaves the old value
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ref_pol_q   <= RST_POL;
      neg_pol_q   <= RST_POL;
      pos_pol_q   <= RST_POL;
      halt_type_q <= RST_HALT;
      fn_q[0]     <= RST_FN;
      fn_q[1]     <= RST_FN;
      fn_q[2]     <= RST_FN;
      direct_q    <= RST_ZERO;
      slow_q      <= RST_SLOW;
      fast_q      <= RST_FAST;
      step_q      <= RST_STEP;
      wait_q      <= RST_WAIT;
      jog_ctrl_q  <= RST_ZERO;
    end else if (wr_go) begin
      if (hit_ref)  ref_pol_q   <= wd[15:0];
      if (hit_neg)  neg_pol_q   <= wd[15:0];
      if (hit_pos)  pos_pol_q   <= wd[15:0];
      if (hit_halt) halt_type_q <= wd[15:0];
      if (hit_fn2)  fn_q[0]     <= wd[15:0];
      if (hit_fn3)  fn_q[1]     <= wd[15:0];
      if (hit_fn4)  fn_q[2]     <= wd[15:0];
      if (hit_dir)  direct_q    <= wd[15:0];
      if (hit_slow) slow_q      <= wd[15:0];
      if (hit_fast) fast_q      <= wd[15:0];
      if (hit_step) step_q      <= wd;
      if (hit_wait) wait_q      <= wd[15:0];
      if (hit_jog)  jog_ctrl_q  <= wd[15:0];
    end
  end

  // answer one cycle after any access
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      par_ack_out   <= 1'b0;
      par_err_out   <= 1'b0;
      par_rdata_out <= 32'h00000000;
    end else begin
      par_ack_out   <= par_wr_in | par_rd_in;
      par_err_out   <= (par_wr_in & ~wr_ok) | (par_rd_in & ~rd_hit);
      par_rdata_out <= par_rd_in ? rd_val : 32'h00000000;
    end
  end

  // per-pin function decode; a pin input is asserted when high
  for (genvar i = 0; i < 3; i++) begin : g_pin
    assign f_fr[i]      = (fn_q[i] == FN_FAULT_RESET) & lvl[i];
    assign f_en[i]      = (fn_q[i] == FN_ENABLE) & lvl[i];
    assign f_halt[i]    = (fn_q[i] == FN_HALT) & lvl[i];
    assign f_jp[i]      = (fn_q[i] == FN_JOG_POS) & lvl[i];
    assign f_jn[i]      = (fn_q[i] == FN_JOG_NEG) & lvl[i];
    assign f_jf[i]      = (fn_q[i] == FN_JOG_FAST) & lvl[i];
    assign f_ref_cfg[i] = fn_q[i] == FN_REF_SWITCH;
    assign f_out[i]     = fn_q[i] >= FN_OUT_FREE;
  end

  // output pin values; pin four has no direct bit so a free output stays low
  wire [2:0] direct_map = {1'b0, direct_q[1:0]};
  for (genvar i = 0; i < 3; i++) begin : g_out
    assign pin_d[i] = (fn_q[i] == FN_OUT_FREE)     ? direct_map[i] :
                      (fn_q[i] == FN_OUT_NO_FAULT) ? ~drive_fault_in :
                      (fn_q[i] == FN_OUT_READY)    ? drive_ready_in : 1'b0;
  end

  // switch evaluation: closed contact opens on trip, open contact closes
  wire neg_present = fn_q[0] == FN_NEG_LIMIT;
  wire neg_trip    = (neg_pol_q == POL_NC) ? ~lvl[0] : (neg_pol_q == POL_NO) & lvl[0];
  wire pos_trip    = (pos_pol_q == POL_NC) ? ~lvl[3] : (pos_pol_q == POL_NO) & lvl[3];
  wire ref_trip    = (ref_pol_q == POL_NC) ? |(f_ref_cfg & ~lvl[2:0])
                                           : |(f_ref_cfg & lvl[2:0]);

  // jog requests from the jog word or from pins
  wire req_pos  = jog_ctrl_q[JOG_BIT_POS] | (|f_jp);
  wire req_neg  = jog_ctrl_q[JOG_BIT_NEG] | (|f_jn);
  wire req_fast = jog_ctrl_q[JOG_BIT_FAST] | (|f_jf);
  wire halt_req = |f_halt;
  wire start_ok = (req_pos ^ req_neg) & ~halt_req;
  wire held     = dir_q ? req_neg : req_pos;
  wire step_zero = step_q == 32'h00000000;
  wire go_step  = (state_q == JOG_IDLE) & start_ok & ~step_zero;
  wire ms_tick  = ms_cnt_q == 17'(MS_CYCLES - 1);
  wire [15:0] sel_speed = req_fast ? fast_q : slow_q;

  // jog sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      JOG_IDLE: begin
        if (start_ok) begin
          state_d = step_zero ? JOG_CONT : JOG_STEP_WAIT;
        end
      end
      JOG_STEP_WAIT: begin
        if (!held) begin
          state_d = JOG_IDLE;
        end else if (ms_left_q == 15'h0000) begin
          state_d = JOG_CONT;
        end
      end
      JOG_CONT: begin
        if (!held) begin
          state_d = JOG_IDLE;
        end
      end
      default: state_d = JOG_IDLE;
    endcase
  end

  // state, direction and the millisecond wait counter
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_q   <= JOG_IDLE;
      dir_q     <= 1'b0;
      ms_cnt_q  <= 17'h00000;
      ms_left_q <= 15'h0000;
    end else begin
      state_q <= state_d;
      if (state_q == JOG_IDLE) begin
        dir_q     <= req_neg;
        ms_cnt_q  <= 17'h00000;
        ms_left_q <= wait_q[14:0];
      end else if (state_q == JOG_STEP_WAIT) begin
        ms_cnt_q <= ms_tick ? 17'h00000 : ms_cnt_q + 17'h00001;
        if (ms_tick && ms_left_q != 15'h0000) begin
          ms_left_q <= ms_left_q - 15'h0001;
        end
      end
    end
  end

  // registered outputs to the drive
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pin_out              <= 3'h0;
      pin_oe_out           <= 3'h0;
      fault_reset_out      <= 1'b0;
      enable_out           <= 1'b0;
      halt_req_out         <= 1'b0;
      halt_decel_ramp_out  <= 1'b0;
      halt_torque_ramp_out <= 1'b0;
      pos_limit_hit_out    <= 1'b0;
      neg_limit_hit_out    <= 1'b0;
      ref_hit_out          <= 1'b0;
      jog_step_start_out   <= 1'b0;
      jog_step_dist_out    <= 32'h00000000;
      jog_speed_out        <= 16'h0000;
    end else begin
      pin_out              <= pin_d & f_out;
      pin_oe_out           <= f_out;
      fault_reset_out      <= local_mode_in & (|f_fr);
      enable_out           <= local_mode_in & (|f_en);
      halt_req_out         <= halt_req;
      // decel ramp needs the profile generator, so fall back to torque
      halt_decel_ramp_out  <= (halt_type_q == HALT_DECEL) & profile_mode_in;
      halt_torque_ramp_out <= (halt_type_q != HALT_DECEL) | ~profile_mode_in;
      pos_limit_hit_out    <= pos_trip;
      neg_limit_hit_out    <= neg_present & neg_trip;
      ref_hit_out          <= homing_active_in & ref_trip;
      jog_step_start_out   <= go_step;
      jog_step_dist_out    <= step_q;
      jog_speed_out        <= (sel_speed > max_ramp_speed_in) ? max_ramp_speed_in
                                                              : sel_speed;
    end
  end

  // jog status seen by the motion profile generator
  assign jog_run_out     = state_q != JOG_IDLE;
  assign jog_cont_out    = state_q == JOG_CONT;
  assign jog_neg_dir_out = dir_q;

  // checks
  a_access_answer:  assert property ((par_wr_in | par_rd_in) |=> par_ack_out)
    else $error("access not answered");
  a_local_only:     assert property (!local_mode_in |=> !fault_reset_out && !enable_out)
    else $error("local function active outside local mode");
  a_pin3_no_limit:  assert property (fn_q[1] != FN_NEG_LIMIT && fn_q[2] != FN_NEG_LIMIT)
    else $error("limit function on pin three or four");
  a_limit_off:      assert property (neg_pol_q == POL_OFF |=> !neg_limit_hit_out)
    else $error("disabled limit reported");
  a_ref_pol_legal:  assert property (ref_pol_q == POL_NC || ref_pol_q == POL_NO)
    else $error("illegal reference evaluation");
  a_ref_homing:     assert property (!homing_active_in |=> !ref_hit_out)
    else $error("reference seen outside homing");
  a_both_no_start:  assert property (state_q == JOG_IDLE && req_pos && req_neg
                      |=> state_q == JOG_IDLE)
    else $error("jog started with both directions");
  a_both_no_effect: assert property (state_q != JOG_IDLE && held
                      |=> state_q != JOG_IDLE && $stable(dir_q))
    else $error("running jog disturbed");
  a_speed_clamp:    assert property (1'b1 |=> jog_speed_out <= $past(max_ramp_speed_in))
    else $error("jog speed above ramp maximum");
  a_zero_step_cont: assert property (state_q == JOG_IDLE && start_ok && step_zero
                      |=> jog_cont_out && !jog_step_start_out)
    else $error("zero step did not run continuously");
  a_wait_holds:     assert property (state_q == JOG_STEP_WAIT && ms_left_q != 15'h0000
                      |=> state_q != JOG_CONT)
    else $error("continuous run before wait ended");
  a_step_first:     assert property (go_step |=> jog_step_start_out && state_q == JOG_STEP_WAIT)
    else $error("step not issued first");
  a_halt_decel:     assert property (halt_decel_ramp_out |-> $past(profile_mode_in)
                      && !halt_torque_ramp_out)
    else $error("decel halt without profile generator");
  a_free_output:    assert property (fn_q[0] == FN_OUT_FREE
                      |=> pin_oe_out[0] && pin_out[0] == $past(direct_q[0]))
    else $error("free output not following direct bit");
  c_step_to_cont:   cover property (state_q == JOG_STEP_WAIT ##1 state_q == JOG_CONT);
  c_zero_step:      cover property (state_q == JOG_IDLE ##1 state_q == JOG_CONT);
  c_bad_write:      cover property (par_wr_in && !wr_ok ##1 par_err_out);
  c_ref_hit:        cover property ($rose(ref_hit_out));
endmodule

/* File: verif/djc_sw_model.sv */
// far-side model: limit contact and local pin levels
module djc_sw_model (
  // commanded states
  input  wire logic       closed_in,
  input  wire logic [2:0] lvl_in,
  // wires at the drive
  output logic            limit_out,
  output logic [2:0]      pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // a closed contact pulls its wire high
  assign limit_out = closed_in;
  assign pin_out = lvl_in;
endmodule

/* File: verif/tb.sv */
// self-checking bench for the drive i/o function and jog block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
  logic clock_in, sys_rst_in, par_wr_in, par_rd_in, profile_mode_in, par_ack_out, par_err_out;
  logic fault_reset_out, enable_out, halt_req_out, halt_decel_ramp_out, halt_torque_ramp_out;
  logic pos_limit_hit_out, neg_limit_hit_out, ref_hit_out, jog_run_out, jog_neg_dir_out;
  logic jog_step_start_out, jog_cont_out, positive_limit_switch_in, cl, err_q;
  logic local_mode_in, homing_active_in;
  logic [15:0] par_addr_in, jog_speed_out;
  logic [31:0] par_wdata_in, par_rdata_out, jog_step_dist_out, rd_q;
  logic [2:0]  pin_in, pin_out, pin_oe_out, lvl;
  int          failures = 0, n_compared = 0;
  djc_sw_model sw_u (.closed_in(cl), .lvl_in(lvl), .limit_out(positive_limit_switch_in),
    .pin_out(pin_in));
  // ramp limit of 100 sits between the two factory jog speeds
  djc_core #(.MS_CYCLES(4)) dut_u (.drive_fault_in(1'b0), .drive_ready_in(1'b0),
    .max_ramp_speed_in(16'h0064), .*);
  // 100 mhz clock
  initial begin clock_in = 1'b0; forever #5 clock_in = ~clock_in; end
  // one access; the answer stands just after the edge on which the core takes the access
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock_in) {par_addr_in, par_wdata_in, par_wr_in, par_rd_in} <= {a, d, w, ~w};
    @(posedge clock_in) {par_wr_in, par_rd_in} <= 2'b00;
    #1 {rd_q, err_q} = {par_rdata_out, par_err_out};
    `CK("ack", 1'b1, par_ack_out)
  endtask
  task automatic wt(input int n); repeat (n) @(posedge clock_in); #1; endtask
  // level change, then room for the pin filter
  task automatic drv(input logic c, input logic [2:0] l);
    @(posedge clock_in) {cl, lvl} <= {c, l};
    wt(8);
  endtask
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // factory values, every function code, out-of-range writes
  task automatic t_regs();
    logic [31:0] f[11] = '{32'h061c0001, 32'h061e0001, 32'h06200001, 32'h062e0003, 32'h07240000,
      32'h07260000, 32'h07280000, 32'h2908003c, 32'h290a00b4, 32'h290e0014, 32'h291001f4};
    logic [15:0] c[11] = '{16'h1, 16'h2, 16'h3, 16'h4, 16'h9, 16'ha, 16'hb, 16'h14, 16'h65,
      16'h66, 16'h67};
    logic [31:0] r[5] = '{32'h061c0000, 32'h07260016, 32'h29120008, 32'h290a3391, 32'h29100000};
    foreach (f[i]) begin
      acc(1'b0, f[i][31:16], 32'h0);
      `CK("factory", {16'h0, f[i][15:0]}, rd_q)
    end
    foreach (c[i]) begin acc(1'b1, 16'h0728, {16'h0, c[i]}); `CK("code", 1'b0, err_q) end
    foreach (r[i]) begin
      acc(1'b1, r[i][31:16], {16'h0, r[i][15:0]});
      `CK("refused", 1'b1, err_q)
    end
    acc(1'b1, 16'h0724, 32'h16); `CK("pin two limit", 1'b0, err_q)
    acc(1'b1, 16'h0724, 32'h0); acc(1'b1, 16'h0728, 32'h0);
    $display("test regs done");
  endtask
  // limit per evaluation, reference outside homing, halt type per mode
  task automatic t_sw();
    drv(1'b0, 3'h0); `CK("nc open", 1'b1, pos_limit_hit_out)
    acc(1'b1, 16'h0620, 32'h2); wt(2); `CK("no open", 1'b0, pos_limit_hit_out)
    drv(1'b1, 3'h0); `CK("no closed", 1'b1, pos_limit_hit_out)
    acc(1'b1, 16'h0620, 32'h0); wt(2); `CK("off", 1'b0, pos_limit_hit_out)
    acc(1'b1, 16'h0726, 32'h14); drv(1'b1, 3'h2); `CK("ref hi", 1'b0, ref_hit_out)
    drv(1'b1, 3'h0); `CK("ref lo", 1'b0, ref_hit_out)
    @(posedge clock_in) homing_active_in <= 1'b1;
    wt(2); `CK("ref homing", 1'b1, ref_hit_out)
    @(posedge clock_in) homing_active_in <= 1'b0;
    `CK("torque", 1'b1, halt_torque_ramp_out)
    acc(1'b1, 16'h062e, 32'h1);
    @(posedge clock_in) profile_mode_in <= 1'b1;
    wt(2); `CK("decel", 1'b1, halt_decel_ramp_out)
    @(posedge clock_in) profile_mode_in <= 1'b0;
    wt(2); `CK("tq", 1'b1, halt_torque_ramp_out)
    $display("test switches done");
  endtask
  // step, wait, continuous run, both bits, fast clamp, zero step
  task automatic t_jog();
    acc(1'b1, 16'h2910, 32'h1); acc(1'b1, 16'h2912, 32'h1); wt(1);
    `CK("step", 2'b10, {jog_step_start_out, jog_cont_out})
    `CK("step set", {32'h14, 16'h3c}, {jog_step_dist_out, jog_speed_out})
    wt(7); `CK("cont", 1'b1, jog_cont_out)
    acc(1'b1, 16'h2912, 32'h3); wt(2); `CK("both run", 1'b1, jog_cont_out)
    acc(1'b1, 16'h2912, 32'h5); wt(2); `CK("clamp", 16'h64, jog_speed_out)
    acc(1'b1, 16'h2912, 32'h0); wt(2); `CK("release", 1'b0, jog_run_out)
    acc(1'b1, 16'h2912, 32'h3); wt(3); `CK("both idle", 1'b0, jog_run_out)
    acc(1'b1, 16'h290e, 32'h0); acc(1'b1, 16'h2912, 32'h2); wt(2);
    `CK("direct", 2'b11, {jog_cont_out, jog_neg_dir_out})
    acc(1'b1, 16'h2912, 32'h0);
    $display("test jog done");
  endtask
  // pin functions: local-only inputs, halt, pin jog, free outputs, negative limit
  task automatic t_pins();
    acc(1'b1, 16'h0724, 32'h2); acc(1'b1, 16'h0726, 32'h3); drv(1'b1, 3'h3);
    `CK("remote", 2'b00, {fault_reset_out, enable_out})
    @(posedge clock_in) local_mode_in <= 1'b1;
    wt(2); `CK("local", 2'b11, {fault_reset_out, enable_out})
    @(posedge clock_in) local_mode_in <= 1'b0;
    // halt pin held high first, so the jog word cannot start a run
    acc(1'b1, 16'h0728, 32'h4); drv(1'b1, 3'h4); acc(1'b1, 16'h2912, 32'h1); wt(2);
    `CK("halt blocks", 2'b10, {halt_req_out, jog_run_out})
    acc(1'b1, 16'h2912, 32'h0); acc(1'b1, 16'h0726, 32'h9); drv(1'b1, 3'h2);
    `CK("pin jog", 2'b11, {jog_run_out, jog_cont_out})
    drv(1'b1, 3'h0); `CK("pin jog off", 1'b0, jog_run_out)
    acc(1'b1, 16'h0724, 32'h65); acc(1'b1, 16'h0726, 32'h66); acc(1'b1, 16'h0728, 32'h65);
    acc(1'b1, 16'h0822, 32'h3); wt(2);
    `CK("outputs", 6'h3b, {pin_oe_out, pin_out})
    acc(1'b1, 16'h0822, 32'h0); wt(2); `CK("direct off", 3'h2, pin_out)
    acc(1'b1, 16'h0724, 32'h16); wt(2);
    `CK("neg limit", 1'b1, neg_limit_hit_out)
    acc(1'b1, 16'h061e, 32'h0); wt(2); `CK("neg off", 1'b0, neg_limit_hit_out)
    $display("test pins done");
  endtask
  // reset for 20 cycles, then the scenarios
  initial begin
    {sys_rst_in, par_wr_in, par_rd_in, profile_mode_in, local_mode_in, homing_active_in} = 6'h20;
    {cl, lvl} = 4'h8;
    {par_addr_in, par_wdata_in} = '0;
    repeat (20) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_regs(); t_sw(); t_jog(); t_pins(); end_sim();
  end
  // the run needs well under a thousand cycles
  initial begin #100us; failures++; end_sim(); end
endmodule
